// ### tae_pkg.sv
// constants shared by the timer channel and its prescaler
// assumes a 32-bit classic wishbone bus with byte addresses
package tae_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0] MODE_IDX = 10'h336;
  localparam logic [9:0] START_IDX = 10'h300;
  localparam logic [9:0] COUNT_IDX = 10'h310;
  localparam logic [9:0] CFG_IDX = 10'h320;

  // ----------------------------------------------------------------
  // mode register fields
  // ----------------------------------------------------------------
  localparam int MODE_OP_LSB = 0;
  localparam int MODE_PULSE_BIT = 2;
  localparam int MODE_EDGE_BIT = 3;
  localparam int MODE_GATE_ON_BIT = 4;
  localparam int MODE_RSVD_BIT = 5;
  localparam int MODE_FREERUN_BIT = 6;
  localparam int MODE_SRC_LSB = 6;
  localparam logic [1:0] OP_TIMER = 2'h0;
  localparam logic [1:0] OP_EVENT = 2'h1;
  localparam logic [1:0] SRC_DIV1_2 = 2'h0;
  localparam logic [1:0] SRC_DIV8 = 2'h1;
  localparam logic [1:0] SRC_DIV32 = 2'h2;
  localparam logic [1:0] SRC_SUB32 = 2'h3;

  // ----------------------------------------------------------------
  // start and configuration register fields
  // ----------------------------------------------------------------
  localparam int START_BIT = 0;
  localparam int CFG_OVERRIDE_BIT = 0;
  localparam int CFG_HALVE_BIT = 1;
  localparam int CFG_UP_BIT = 2;
  localparam int CFG_EVSRC_LSB = 3;
  localparam int CFG_POLINV_BIT = 5;
  localparam logic [1:0] EV_PIN = 2'h0;
  localparam logic [1:0] EV_TB2 = 2'h1;
  localparam logic [1:0] EV_PREV = 2'h2;
  localparam logic [1:0] EV_NEXT = 2'h3;

  // ----------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [4:0] PRESC_RST = 5'h00;

endpackage : tae_pkg

// ### tae_prescaler.sv
// free-running divider giving one-cycle ticks at /2, /8 and /32
// assumes the peripheral clock as its only clock
module tae_prescaler (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // ticks
  output logic tick_div2,
  output logic tick_div8,
  output logic tick_div32
);

  logic [4:0] div_ff;
  logic [4:0] nxt_div;
  logic t2_ff, t8_ff, t32_ff;
  logic nxt_t2, nxt_t8, nxt_t32;

  always_comb begin
    nxt_div = div_ff + 5'h01;
    nxt_t2 = (div_ff[0] == 1'b1);
    nxt_t8 = (div_ff[2:0] == 3'h7);
    nxt_t32 = (div_ff == 5'h1f);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div_ff <= tae_pkg::PRESC_RST;
      t2_ff <= 1'b0;
      t8_ff <= 1'b0;
      t32_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      t2_ff <= nxt_t2;
      t8_ff <= nxt_t8;
      t32_ff <= nxt_t32;
    end
  end

  assign tick_div2 = t2_ff;
  assign tick_div8 = t8_ff;
  assign tick_div32 = t32_ff;

endmodule // tae_prescaler

// ### tae_channel.sv
// one 16-bit timer channel: timer mode and event counter mode
// assumes neighbour/timer b2 events are one-cycle pulses on clk;
// channel_input_pin and subclock_div32 are asynchronous
//
// Chosen here: the Wishbone interface to the registers.

// Operation
// R1: mode field 00 in bits 1..0 selects timer mode.
// R2: pulse-out select 0 leaves output pin as I/O, 1 drives pulse.
// R3: gate 0x off, 10 counts while input low, 11 while high.
// R4: software keeps mode bit 5 zero in timer mode.
// R5: source field 00 div1/div2, 01 div8, 10 div32, 11 subclock/32.
// R6: source field used only while source override bit is 0.
// R7: halve-select bit picks div1 or div2 when source is 00.
// R8: event mode counts selectable input edges or timer b2 events.
// R9: event mode may count previous or next channel wrap events.
// R10: event mode direction up or down chosen by software.
// R11: reload type reloads on wrap; free-run keeps counting.
// R12: reload n gives FFFFh-n+1 up counts, n+1 down counts.
// R13: start bit 1 starts counting, 0 stops it.
// R14: event mode raises interrupt request on every wrap.
// R15: input pin is count input; counter reads return live count.
// R16: write stopped loads reload and counter; running, reload only.
// R17: pulse output inverts each wrap, low while stopped.
// R18: inverted polarity drives output high while stopped.
// R19: timer mode decrements and reloads on each underflow.
// R20: mode field 01 selects event counter mode.
// R21: event mode bit 3: 0 falling, 1 rising edge counted.
// R22: event mode bit 6: 0 reload type, 1 free-run type.
// R23: gate and count input pins synchronised before use.
module tae_channel (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // pins
  input wire logic channel_input_pin,
  input wire logic subclock_div32,
  output logic channel_output_pin,
  output logic channel_output_pin_oe,
  // neighbouring timers
  input wire logic tb2_wrap_i,
  input wire logic prev_wrap_i,
  input wire logic next_wrap_i,
  output logic wrap_o,
  // interrupt request
  output logic irq_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] merge_byte(input logic [7:0] old_v,
                                            input logic [7:0] new_v,
                                            input logic en);
    merge_byte = en ? new_v : old_v;
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic ack_ff, nxt_ack;
  logic [31:0] rdat_ff, nxt_rdat;
  logic [7:0] mode_ff, nxt_mode;
  logic [7:0] cfg_ff, nxt_cfg;
  logic start_ff, nxt_start;
  logic [15:0] reload_ff, nxt_reload;
  logic [15:0] count_ff, nxt_count;
  logic out_lvl_ff, nxt_out_lvl;
  logic wrap_ff, nxt_wrap;
  logic irq_ff, nxt_irq;
  logic in_s1_ff, in_s2_ff, in_s3_ff;
  logic sub_s1_ff, sub_s2_ff, sub_s3_ff;
  logic tick_div2, tick_div8, tick_div32;
  logic [9:0] idx;
  logic wr_go;
  logic wr_mode, wr_cfg, wr_start, wr_count;
  logic [15:0] wr_count_val;
  logic sub_tick;
  logic src_tick;
  logic gate_ok;
  logic ext_edge;
  logic ev_tick;
  logic count_tick;
  logic is_timer, is_event;
  logic count_up;
  logic at_wrap;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      in_s1_ff <= 1'b0;
      in_s2_ff <= 1'b0;
      in_s3_ff <= 1'b0;
      sub_s1_ff <= 1'b0;
      sub_s2_ff <= 1'b0;
      sub_s3_ff <= 1'b0;
    end else begin
      in_s1_ff <= channel_input_pin; // R23
      in_s2_ff <= in_s1_ff; // R23
      in_s3_ff <= in_s2_ff;
      sub_s1_ff <= subclock_div32;
      sub_s2_ff <= sub_s1_ff;
      sub_s3_ff <= sub_s2_ff;
    end
  end

  // ----------------------------------------------------------------
  // count sources
  // ----------------------------------------------------------------
  tae_prescaler u_presc (
    .clk(clk),
    .reset(reset),
    .tick_div2(tick_div2),
    .tick_div8(tick_div8),
    .tick_div32(tick_div32)
  );

  assign sub_tick = sub_s2_ff & ~sub_s3_ff;
  assign is_timer = (mode_ff[tae_pkg::MODE_OP_LSB +: 2] == tae_pkg::OP_TIMER); // R1
  assign is_event = (mode_ff[tae_pkg::MODE_OP_LSB +: 2] == tae_pkg::OP_EVENT); // R20
  assign count_up = is_event & cfg_ff[tae_pkg::CFG_UP_BIT]; // R10

  always_comb begin
    src_tick = 1'b1;
    if (cfg_ff[tae_pkg::CFG_OVERRIDE_BIT]) begin
      // override path: undivided clock stands in for the external selector
      src_tick = 1'b1; // R6
    end else begin
      case (mode_ff[tae_pkg::MODE_SRC_LSB +: 2]) // R5
        tae_pkg::SRC_DIV1_2: src_tick = cfg_ff[tae_pkg::CFG_HALVE_BIT] ? tick_div2 : 1'b1; // R7
        tae_pkg::SRC_DIV8: src_tick = tick_div8;
        tae_pkg::SRC_DIV32: src_tick = tick_div32;
        default: src_tick = sub_tick;
      endcase
    end
    // gate level compares against bit 3: 0 counts on low, 1 on high
    gate_ok = ~mode_ff[tae_pkg::MODE_GATE_ON_BIT] |
              (in_s2_ff == mode_ff[tae_pkg::MODE_EDGE_BIT]); // R3
    ext_edge = mode_ff[tae_pkg::MODE_EDGE_BIT] ? (in_s2_ff & ~in_s3_ff)
                                               : (~in_s2_ff & in_s3_ff); // R21
    case (cfg_ff[tae_pkg::CFG_EVSRC_LSB +: 2])
      tae_pkg::EV_PIN: ev_tick = ext_edge; // R8 R15
      tae_pkg::EV_TB2: ev_tick = tb2_wrap_i; // R8
      tae_pkg::EV_PREV: ev_tick = prev_wrap_i; // R9
      default: ev_tick = next_wrap_i; // R9
    endcase
    count_tick = start_ff & ((is_timer & src_tick & gate_ok) | (is_event & ev_tick)); // R13
    at_wrap = count_up ? (count_ff == tae_pkg::COUNT_MAX) : (count_ff == 16'h0000);
  end

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  // writes land on the edge where the master sees ack
  assign idx = wb_adr_i[11:2];
  assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff;

  always_comb begin
    wr_mode = 1'b0;
    wr_cfg = 1'b0;
    wr_start = 1'b0;
    wr_count = 1'b0;
    if (idx == tae_pkg::MODE_IDX) begin
      wr_mode = wr_go & wb_sel_i[0];
    end else if (idx == tae_pkg::CFG_IDX) begin
      wr_cfg = wr_go & wb_sel_i[0];
    end else if (idx == tae_pkg::START_IDX) begin
      wr_start = wr_go & wb_sel_i[0];
    end else if (idx == tae_pkg::COUNT_IDX) begin
      wr_count = wr_go & (wb_sel_i[1:0] != 2'h0);
    end
    wr_count_val = {merge_byte(reload_ff[15:8], wb_dat_i[15:8], wb_sel_i[1]),
                    merge_byte(reload_ff[7:0], wb_dat_i[7:0], wb_sel_i[0])};
  end

  always_comb begin
    nxt_ack = wb_cyc_i & wb_stb_i & ~ack_ff;
    nxt_rdat = 32'h0000_0000;
    if (idx == tae_pkg::MODE_IDX) begin
      nxt_rdat = {24'h00_0000, mode_ff};
    end else if (idx == tae_pkg::CFG_IDX) begin
      nxt_rdat = {24'h00_0000, cfg_ff};
    end else if (idx == tae_pkg::START_IDX) begin
      nxt_rdat = {31'h0000_0000, start_ff};
    end else if (idx == tae_pkg::COUNT_IDX) begin
      nxt_rdat = {16'h0000, count_ff}; // R15
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= nxt_ack;
      rdat_ff <= nxt_rdat;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_comb begin
    nxt_mode = mode_ff;
    nxt_cfg = cfg_ff;
    nxt_start = start_ff;
    // bit 5 is stored as written; software keeps it 0 in timer mode
    if (wr_mode) begin
      nxt_mode = wb_dat_i[7:0]; // R4
    end
    if (wr_cfg) begin
      nxt_cfg = {2'h0, wb_dat_i[5:0]};
    end
    if (wr_start) begin
      nxt_start = wb_dat_i[tae_pkg::START_BIT]; // R13
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode_ff <= tae_pkg::MODE_RST;
      cfg_ff <= tae_pkg::CFG_RST;
      start_ff <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      cfg_ff <= nxt_cfg;
      start_ff <= nxt_start;
    end
  end

  // ----------------------------------------------------------------
  // counter, reload and pulse output
  // ----------------------------------------------------------------
  always_comb begin
    nxt_reload = reload_ff;
    nxt_count = count_ff;
    nxt_wrap = 1'b0;
    nxt_irq = 1'b0;
    nxt_out_lvl = out_lvl_ff;
    if (count_tick) begin
      if (at_wrap) begin
        nxt_wrap = 1'b1;
        nxt_irq = 1'b1; // R14
        nxt_out_lvl = ~out_lvl_ff; // R17
        if (is_event & mode_ff[tae_pkg::MODE_FREERUN_BIT]) begin
          nxt_count = count_up ? 16'h0000 : tae_pkg::COUNT_MAX; // R11 R22
        end else begin
          nxt_count = reload_ff; // R11 R12 R19
        end
      end else begin
        nxt_count = count_up ? count_ff + 16'h0001 : count_ff - 16'h0001; // R10 R19
      end
    end
    if (!start_ff) begin
      nxt_out_lvl = 1'b0; // R17
    end
    if (wr_count) begin
      nxt_reload = wr_count_val; // R16
      if (!start_ff) begin
        nxt_count = wr_count_val; // R16
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reload_ff <= tae_pkg::COUNT_RST;
      count_ff <= tae_pkg::COUNT_RST;
      out_lvl_ff <= 1'b0;
      wrap_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      reload_ff <= nxt_reload;
      count_ff <= nxt_count;
      out_lvl_ff <= nxt_out_lvl;
      wrap_ff <= nxt_wrap;
      irq_ff <= nxt_irq;
    end
  end

  // ----------------------------------------------------------------
  // pin drivers, registered so outputs come straight off flops
  // ----------------------------------------------------------------
  logic pin_ff, nxt_pin;
  logic pin_oe_ff, nxt_pin_oe;

  always_comb begin
    nxt_pin = nxt_out_lvl ^ nxt_cfg[tae_pkg::CFG_POLINV_BIT]; // R18
    nxt_pin_oe = nxt_mode[tae_pkg::MODE_PULSE_BIT]; // R2
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_ff <= 1'b0;
      pin_oe_ff <= 1'b0;
    end else begin
      pin_ff <= nxt_pin;
      pin_oe_ff <= nxt_pin_oe;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
  assign channel_output_pin = pin_ff;
  assign channel_output_pin_oe = pin_oe_ff;
  assign wrap_o = wrap_ff;
  assign irq_o = irq_ff;

endmodule // tae_channel

// ### tae_channel_sva.sv
// checker for one timer channel, sees only the channel's ports
// assumes one clock and the async active-high reset
module tae_channel_sva (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  // pins and events
  input wire logic channel_output_pin,
  input wire logic channel_output_pin_oe,
  input wire logic wrap_o,
  input wire logic irq_o
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered");
  a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_read_upper: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  a_mode_width: assert property (wb_ack_o && !wb_we_i && wb_adr_i[11:2] == tae_pkg::MODE_IDX
    |-> wb_dat_o[31:8] == 24'h000000)
    else $error("mode read wider than a byte");
  a_irq_wrap: assert property (irq_o == wrap_o)
    else $error("irq and wrap disagree");
  a_oe_cause: assert property ($changed(channel_output_pin_oe)
    |-> $past(wb_ack_o) || $past(wb_ack_o, 2))
    else $error("output enable moved without a write");
  // a pin edge needs a wrap or a start/stop/polarity write shortly before
  // a polarity write moves the pin one cycle after ack, a stop write two cycles after it
  a_pin_cause: assert property ($changed(channel_output_pin) |-> irq_o || $past(irq_o)
    || $past(irq_o, 2) || $past(wb_ack_o) || $past(wb_ack_o, 2) || $past(wb_ack_o, 3))
    else $error("output pin moved without cause");
  c_irq: cover property (irq_o);
  c_write: cover property (wb_ack_o && wb_we_i);
  c_pin_rise: cover property ($rose(channel_output_pin));
endmodule // tae_channel_sva

bind tae_channel tae_channel_sva i_tae_channel_sva (.clk(clk), .reset(reset),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .channel_output_pin(channel_output_pin),
  .channel_output_pin_oe(channel_output_pin_oe), .wrap_o(wrap_o), .irq_o(irq_o));

// ### tae_ext_model.sv
// stand-in for the pulse source and the neighbouring timers
// assumes the bench asks for events with one-cycle fire bits
module tae_ext_model (
  // clock and requests
  input wire logic clk,
  input wire logic pin_lvl,
  input wire logic [2:0] fire,
  // toward the channel
  output logic channel_input_pin,
  output logic subclock_div32,
  output logic tb2_wrap_i,
  output logic prev_wrap_i,
  output logic next_wrap_i
);
  logic [5:0] sub_cnt;
  initial begin
    {channel_input_pin, tb2_wrap_i, prev_wrap_i, next_wrap_i} = 4'h0;
    sub_cnt = 6'h00;
  end
  // wraps last one cycle, as a real channel's do
  always @(posedge clk) begin
    tb2_wrap_i <= fire[0];
    prev_wrap_i <= fire[1];
    next_wrap_i <= fire[2];
    channel_input_pin <= pin_lvl;
    sub_cnt <= sub_cnt + 6'h01;
  end
  assign subclock_div32 = sub_cnt[5];
endmodule // tae_ext_model

// ### testbench.sv
// self-checking bench for one timer channel
// assumes the bound checker and the event model beside the channel
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [9:0] MD = tae_pkg::MODE_IDX;
  localparam logic [9:0] ST = tae_pkg::START_IDX;
  localparam logic [9:0] CT = tae_pkg::COUNT_IDX;
  localparam logic [9:0] CF = tae_pkg::CFG_IDX;
  logic clk, reset, cyc, stb, we, pin_lvl, pin, ack, sub, tb2, prv, nxt, irq, opin, oe, wrp;
  logic [11:0] adr;
  logic [31:0] wdat, rdat, dout;
  logic [2:0] fire;
  int fails, checked, irqs, wraps, base, wbase;
  tae_channel i_tae_channel (.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dout),
    .wb_ack_o(ack), .channel_input_pin(pin), .subclock_div32(sub),
    .channel_output_pin(opin), .channel_output_pin_oe(oe), .tb2_wrap_i(tb2),
    .prev_wrap_i(prv), .next_wrap_i(nxt), .wrap_o(wrp), .irq_o(irq));
  tae_ext_model i_tae_ext_model (.clk(clk), .pin_lvl(pin_lvl), .fire(fire),
    .channel_input_pin(pin), .subclock_div32(sub), .tb2_wrap_i(tb2), .prev_wrap_i(prv),
    .next_wrap_i(nxt));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic report_and_stop;
    $display("mismatches %0d, comparisons %0d", fails, checked);
    if (fails == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic [9:0] i, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk);
    {cyc, stb, we} <= {2'h3, w};
    adr <= {i, 2'h0};
    wdat <= d;
    // sampled values here are those seen at the edge
    for (n = 0; n < 20 && ack !== 1'b1; n++) @(posedge clk);
    rdat = dout;
    {cyc, stb, we} <= 3'h0;
    if (n == 20) begin
      fails++;
      report_and_stop();
    end
  endtask
  task automatic wr(input logic [9:0] i, input logic [31:0] d);
    bus(i, 1'b1, d);
  endtask
  task automatic rd(input logic [9:0] i, input logic [31:0] exp);
    bus(i, 1'b0, 32'h0);
    check(rdat, exp);
  endtask
  task automatic ev(input logic [2:0] f, input int k);
    repeat (k) begin
      @(posedge clk);
      fire <= f;
      @(posedge clk);
      fire <= 3'h0;
    end
    repeat (4) @(posedge clk);
  endtask
  // the first pulse only aligns the count; the gap up to the second pulse is the one measured
  task automatic period(input int exp);
    int n;
    int m;
    for (n = 0; n < 600 && irq !== 1'b1; n++) @(posedge clk);
    @(posedge clk);
    for (m = 1; m < 600 && irq !== 1'b1; m++) @(posedge clk);
    if (n == 600 || m == 600) begin
      fails++;
      report_and_stop();
    end
    check(32'(m), 32'(exp));
  endtask
  always @(posedge clk) begin
    if (irq === 1'b1) irqs++;
    if (wrp === 1'b1) wraps++;
  end
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    report_and_stop();
  end
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    reset = 1'b1;
    {cyc, stb, we, pin_lvl, fire} = 7'h00;
    adr = 12'h000;
    wdat = 32'h0;
    fails = 0;
    checked = 0;
    irqs = 0;
    wraps = 0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    rd(MD, 32'h0);
    rd(CT, 32'h0);
    rd(10'h001, 32'h0);
    wr(CF, 32'h08);
    wr(MD, 32'h05);
    wr(CT, 32'h03);
    wr(ST, 32'h01);
    base = irqs;
    wbase = wraps;
    ev(3'h1, 3);
    rd(CT, 32'h0);
    ev(3'h1, 1);
    check(32'(irqs - base), 32'h1);
    check(32'(wraps - wbase), 32'h1);
    rd(CT, 32'h3);
    check({31'h0, opin}, 32'h1);
    check({31'h0, oe}, 32'h1);
    wr(CT, 32'h07);
    rd(CT, 32'h3);
    wr(ST, 32'h00);
    repeat (3) @(posedge clk);
    check({31'h0, opin}, 32'h0);
    wr(CF, 32'h28);
    repeat (3) @(posedge clk);
    check({31'h0, opin}, 32'h1);
    wr(CT, 32'h02);
    rd(CT, 32'h2);
    wr(CF, 32'h14);
    wr(CT, 32'hfffd);
    wr(ST, 32'h01);
    ev(3'h2, 2);
    rd(CT, 32'hffff);
    base = irqs;
    ev(3'h2, 1);
    check(32'(irqs - base), 32'h1);
    rd(CT, 32'hfffd);
    wr(ST, 32'h00);
    wr(CF, 32'h18);
    wr(MD, 32'h41);
    wr(CT, 32'h01);
    wr(ST, 32'h01);
    ev(3'h4, 2);
    rd(CT, 32'hffff);
    wr(ST, 32'h00);
    wr(CF, 32'h00);
    wr(MD, 32'h09);
    wr(CT, 32'h05);
    wr(ST, 32'h01);
    pin_lvl <= 1'b1;
    repeat (8) @(posedge clk);
    rd(CT, 32'h4);
    pin_lvl <= 1'b0;
    repeat (8) @(posedge clk);
    rd(CT, 32'h4);
    wr(MD, 32'h01);
    pin_lvl <= 1'b1;
    repeat (8) @(posedge clk);
    pin_lvl <= 1'b0;
    repeat (8) @(posedge clk);
    rd(CT, 32'h3);
    wr(ST, 32'h00);
    wr(CF, 32'h01);
    wr(MD, 32'h00);
    wr(CT, 32'h03);
    wr(ST, 32'h01);
    period(4);
    wr(CF, 32'h00);
    wr(MD, 32'h40);
    period(32);
    wr(MD, 32'h00);
    wr(CF, 32'h02);
    period(8);
    // halve bit set too: only the override can bring the period back to four
    wr(CF, 32'h03);
    period(4);
    wr(MD, 32'h18);
    repeat (4) @(posedge clk);
    base = irqs;
    repeat (40) @(posedge clk);
    check(32'(irqs - base), 32'h0);
    pin_lvl <= 1'b1;
    period(4);
    wr(MD, 32'h10);
    repeat (4) @(posedge clk);
    base = irqs;
    repeat (40) @(posedge clk);
    check(32'(irqs - base), 32'h0);
    pin_lvl <= 1'b0;
    period(4);
    wr(MD, 32'h08);
    period(4);
    wr(CF, 32'h00);
    wr(MD, 32'h80);
    period(128);
    wr(MD, 32'hc0);
    period(256);
    report_and_stop();
  end
endmodule // testbench
